/* File: logic/bsc_pkg.sv */
// cell map, kinds and reset values for the boundary-scan cell chain
package bsc_pkg;

  localparam int CELLS = 60;
  localparam int NO_ENABLE = 0;
  localparam int DISPLAY_BUS_DRIVE_ENABLE_CELL = 6;
  localparam int PORT_PAD_DRIVE_ENABLE_CELL = 41;
  localparam int MODE_BITS = 3;
  localparam int MODE_PAD_CELLS = 0;
  localparam int MODE_CORE_CELLS = 1;
  localparam int MODE_OUTPUTS_OFF = 2;
  localparam logic DATA_RESET = 1'h0;
  localparam logic ENABLE_RESET = 1'h1;

  // kind of each cell; active_low_enable_cell_type drives its group at 0
  typedef enum logic [1:0] {
    BSC_IN = 2'h0,
    BSC_OUT = 2'h1,
    BSC_EN = 2'h2
  } bsc_kind_e;

  // cell kind by chain position, 1 nearest the serial input
  function automatic bsc_kind_e cell_kind(input int i);
    case (i)
      1, 3, 4, 10, 14, 16, 18, 20, 22, 24, 27, 29, 31, 33, 36, 39,
      46, 50, 51, 52, 53, 56, 58, 59: return BSC_IN;
      DISPLAY_BUS_DRIVE_ENABLE_CELL, PORT_PAD_DRIVE_ENABLE_CELL: return BSC_EN;
      default: return BSC_OUT;
    endcase
  endfunction

  // enable cell that governs an output cell, NO_ENABLE if driven always
  function automatic int enable_of(input int i);
    case (i)
      5, 11, 15, 17, 19, 21, 23, 25, 28, 30, 32, 34: return DISPLAY_BUS_DRIVE_ENABLE_CELL;
      40: return PORT_PAD_DRIVE_ENABLE_CELL;
      default: return NO_ENABLE;
    endcase
  endfunction

  // update latches come out of reset with both enable-cell groups released
  function automatic logic [CELLS:1] upd_reset_value();
    logic [CELLS:1] v;
    v = '0;
    for (int i = 1; i <= CELLS; i++) begin
      v[i] = (cell_kind(i) == BSC_EN) ? ENABLE_RESET : DATA_RESET;
    end
    return v;
  endfunction

  localparam logic [CELLS:1] UPD_RESET = upd_reset_value();

endpackage

/* File: logic/bsc_sync.sv */
// two flip-flop level synchroniser, also used for reset release
`timescale 1ns/100ps
module bsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bsc_sync_s;

  bsc_sync_s cur_ff;
  bsc_sync_s nxt_ff;

  // first stage feeds only the second stage
  always_comb begin
    nxt_ff.s1 = d;
    nxt_ff.s2 = cur_ff.s1;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign q = cur_ff.s2;

endmodule

/* File: logic/bsc_chain.sv */
// boundary-scan cell chain: shift/update on the test clock, pad and core muxing on clk
//
// Functional notes
// - cells form one fixed serial order, cell 1 at serial input.
// - every covered output pad is three-state, releasable or driven 0/1.
// - input cells substitute stored test value toward core under a test instruction.
// - chain holds input, output and output-enable cells at fixed positions.
// - chain sits between serial ports only for sample, extest, intest; clamps reuse.
// - active-low enable cells gate bus drivers, driving their group when 0.
`timescale 1ns/100ps
module bsc_chain (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdi,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  input wire logic sel_sample,
  input wire logic sel_extest,
  input wire logic sel_intest,
  input wire logic sel_clamp,
  input wire logic sel_clamp_with_outputs_disabled,
  input wire logic sel_highz,
  output logic chain_tdo,
  input wire logic [bsc_pkg::CELLS:1] pad_in,
  input wire logic [bsc_pkg::CELLS:1] core_out,
  input wire logic [bsc_pkg::CELLS:1] core_oe_n,
  output logic [bsc_pkg::CELLS:1] to_core,
  output logic [bsc_pkg::CELLS:1] pad_out,
  output logic [bsc_pkg::CELLS:1] pad_oe
);

  typedef struct packed {
    logic [bsc_pkg::CELLS:1] sh;
    logic [bsc_pkg::CELLS:1] upd;
    logic upd_tgl;
    logic [bsc_pkg::MODE_BITS-1:0] mode;
  } bsc_tck_s;

  typedef struct packed {
    logic tgl_seen;
    logic [bsc_pkg::CELLS:1] upd_c;
    logic [bsc_pkg::CELLS:1] to_core;
    logic [bsc_pkg::CELLS:1] pad_out;
    logic [bsc_pkg::CELLS:1] pad_oe;
  } bsc_clk_s;

  bsc_tck_s tck_ff;
  bsc_tck_s nxt_tck_ff;
  bsc_clk_s clk_ff;
  bsc_clk_s nxt_clk_ff;

  logic rst_clk_n;
  logic rst_tck_n;
  logic [bsc_pkg::CELLS:1] pad_t;
  logic [bsc_pkg::CELLS:1] core_t;
  logic [bsc_pkg::CELLS:1] coe_t;
  logic [bsc_pkg::CELLS:1] pad_c;
  logic [bsc_pkg::MODE_BITS-1:0] mode_c;
  logic tgl_c;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and crossings

  // reset release, asserted at once, lifted after two edges
  bsc_sync #(.W(1)) u_rst_clk (
    .clk(clk),
    .rst_n(rst_n),
    .d(1'h1),
    .q(rst_clk_n)
  );

  bsc_sync #(.W(1)) u_rst_tck (
    .clk(tck),
    .rst_n(trst_n),
    .d(1'h1),
    .q(rst_tck_n)
  );

  // pads and core signals into the test clock for capture
  bsc_sync #(.W(3 * bsc_pkg::CELLS)) u_cap_tck (
    .clk(tck),
    .rst_n(rst_tck_n),
    .d({pad_in, core_out, core_oe_n}),
    .q({pad_t, core_t, coe_t})
  );

  // pads into clk for the normal path toward the core
  bsc_sync #(.W(bsc_pkg::CELLS)) u_pad_clk (
    .clk(clk),
    .rst_n(rst_clk_n),
    .d(pad_in),
    .q(pad_c)
  );

  // registered mode levels and update toggle into clk
  bsc_sync #(.W(bsc_pkg::MODE_BITS + 1)) u_mode_clk (
    .clk(clk),
    .rst_n(rst_clk_n),
    .d({tck_ff.mode, tck_ff.upd_tgl}),
    .q({mode_c, tgl_c})
  );

  ////////////////////////////////////////////////////////////////////////////
  // test clock domain: capture, shift, update

  // chain only connected for sample, extest, intest
  always_comb begin
    logic chain_sel;
    logic [bsc_pkg::CELLS:1] capv;
    chain_sel = sel_sample | sel_extest | sel_intest;
    capv = '0;
    nxt_tck_ff = tck_ff;
    for (int i = 1; i <= bsc_pkg::CELLS; i++) begin
      unique case (bsc_pkg::cell_kind(i))
        bsc_pkg::BSC_IN: capv[i] = sel_intest ? ~tck_ff.upd[i] : pad_t[i];
        bsc_pkg::BSC_OUT: capv[i] = core_t[i];
        bsc_pkg::BSC_EN: capv[i] = coe_t[i];
      endcase
    end
    nxt_tck_ff.mode[bsc_pkg::MODE_PAD_CELLS] =
      sel_extest | sel_intest | sel_clamp | sel_clamp_with_outputs_disabled;
    nxt_tck_ff.mode[bsc_pkg::MODE_CORE_CELLS] = sel_extest | sel_intest;
    nxt_tck_ff.mode[bsc_pkg::MODE_OUTPUTS_OFF] =
      sel_clamp_with_outputs_disabled | sel_highz;
    if (chain_sel && capture_dr) begin
      nxt_tck_ff.sh = capv;
    end else if (chain_sel && shift_dr) begin
      nxt_tck_ff.sh = {tck_ff.sh[bsc_pkg::CELLS-1:1], tdi};
    end
    // clamps leave the update latches untouched
    if (chain_sel && update_dr) begin
      nxt_tck_ff.upd = tck_ff.sh;
      nxt_tck_ff.upd_tgl = ~tck_ff.upd_tgl;
    end
  end

  // test clock state register
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      tck_ff <= '{sh: '0, upd: bsc_pkg::UPD_RESET, upd_tgl: 1'h0, mode: '0};
    end else begin
      tck_ff <= nxt_tck_ff;
    end
  end

  assign chain_tdo = tck_ff.sh[bsc_pkg::CELLS];

  ////////////////////////////////////////////////////////////////////////////
  // system clock domain: pad and core muxing

  // update word taken on a toggle edge, held stable by the test side
  always_comb begin
    int en;
    logic drive;
    en = 0;
    drive = 1'h0;
    nxt_clk_ff = clk_ff;
    nxt_clk_ff.tgl_seen = tgl_c;
    if (tgl_c != clk_ff.tgl_seen) begin
      nxt_clk_ff.upd_c = tck_ff.upd;
    end
    for (int i = 1; i <= bsc_pkg::CELLS; i++) begin
      nxt_clk_ff.to_core[i] = 1'h0;
      nxt_clk_ff.pad_out[i] = 1'h0;
      nxt_clk_ff.pad_oe[i] = 1'h0;
      en = bsc_pkg::enable_of(i);
      unique case (bsc_pkg::cell_kind(i))
        bsc_pkg::BSC_IN: begin
          nxt_clk_ff.to_core[i] = mode_c[bsc_pkg::MODE_CORE_CELLS] ?
                                  clk_ff.upd_c[i] : pad_c[i];
        end
        bsc_pkg::BSC_OUT: begin
          nxt_clk_ff.pad_out[i] = mode_c[bsc_pkg::MODE_PAD_CELLS] ?
                                  clk_ff.upd_c[i] : core_out[i];
          if (en == bsc_pkg::NO_ENABLE) begin
            drive = 1'h1;
          end else if (mode_c[bsc_pkg::MODE_PAD_CELLS]) begin
            drive = ~clk_ff.upd_c[en];
          end else begin
            drive = ~core_oe_n[en];
          end
          nxt_clk_ff.pad_oe[i] = drive & ~mode_c[bsc_pkg::MODE_OUTPUTS_OFF];
        end
        bsc_pkg::BSC_EN: begin
          nxt_clk_ff.to_core[i] = 1'h0;
        end
      endcase
    end
  end

  // system clock state register
  always_ff @(posedge clk or negedge rst_clk_n) begin
    if (!rst_clk_n) begin
      clk_ff <= '{tgl_seen: 1'h0, upd_c: bsc_pkg::UPD_RESET, to_core: '0,
                  pad_out: '0, pad_oe: '0};
    end else begin
      clk_ff <= nxt_clk_ff;
    end
  end

  assign to_core = clk_ff.to_core;
  assign pad_out = clk_ff.pad_out;
  assign pad_oe = clk_ff.pad_oe;

endmodule

/* File: testbench/bsc_chain_monitor.sv */
// assertion checker for the boundary-scan cell chain
`timescale 1ns/100ps
module bsc_chain_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic sel_sample,
  input wire logic sel_extest,
  input wire logic sel_intest,
  input wire logic sel_clamp_with_outputs_disabled,
  input wire logic sel_highz,
  input wire logic chain_tdo,
  input wire logic [bsc_pkg::CELLS:1] core_out,
  input wire logic [bsc_pkg::CELLS:1] to_core,
  input wire logic [bsc_pkg::CELLS:1] pad_out,
  input wire logic [bsc_pkg::CELLS:1] pad_oe
);
  // chain instruction active
  wire logic chn = sel_sample | sel_extest | sel_intest;
  property p_hold;
    @(posedge tck) disable iff (!trst_n) !((capture_dr | shift_dr) & chn) |=> $stable(chain_tdo);
  endproperty
  a_hold: assert property (p_hold) else $error("tdo moved without a shift");
  property p_first;
    @(posedge tck) disable iff (!trst_n) capture_dr & sel_sample |=> chain_tdo == $past(core_out[60]);
  endproperty
  a_first: assert property (p_first) else $error("first bit out not cell 60");
  property p_in;
    @(posedge clk) disable iff (!rst_n) !(pad_oe[1] | pad_out[3] | pad_oe[59]);
  endproperty
  a_in: assert property (p_in) else $error("input cell drives a pad");
  property p_grp;
    @(posedge clk) disable iff (!rst_n) pad_oe[5] == pad_oe[34] && pad_oe[11] == pad_oe[23];
  endproperty
  a_grp: assert property (p_grp) else $error("bus group enables differ");
  property p_core;
    @(posedge clk) disable iff (!rst_n) !(to_core[2] | to_core[6] | to_core[60]);
  endproperty
  a_core: assert property (p_core) else $error("non-input cell feeds core");
  property p_en;
    @(posedge clk) disable iff (!rst_n) !(pad_oe[6] | pad_oe[41] | pad_out[41]);
  endproperty
  a_en: assert property (p_en) else $error("enable cell reaches a pad");
  property p_off;
    @(posedge clk) disable iff (!rst_n)
      $fell(pad_oe[2]) |-> sel_highz | sel_clamp_with_outputs_disabled;
  endproperty
  a_off: assert property (p_off) else $error("output released without cause");
endmodule
//////////////////////////////////////////
bind bsc_chain bsc_chain_monitor u_mon (.clk, .rst_n, .tck, .trst_n, .capture_dr, .shift_dr,
  .sel_sample, .sel_extest, .sel_intest, .sel_clamp_with_outputs_disabled, .sel_highz,
  .chain_tdo, .core_out, .to_core, .pad_out, .pad_oe);

/* File: testbench/bsc_tester.sv */
// behavioural boundary-scan tester on the test port
`timescale 1ns/100ps
module bsc_tester (
  output logic tck,
  output logic trst_n,
  output logic tdi,
  output logic capture_dr,
  output logic shift_dr,
  output logic update_dr,
  output logic [5:0] sel,
  input wire logic chain_tdo
);
  // idle port, test reset released early
  initial begin
    {tck, tdi, capture_dr, shift_dr, update_dr, sel, trst_n} = '0;
    #400 trst_n = 1'b1;
  end
  // one test clock; signals change after the falling edge
  task automatic cyc(input logic c, s, u, d);
    {capture_dr, shift_dr, update_dr, tdi} = {c, s, u, d};
    #16 tck = 1'b1;
    #16 tck = 1'b0;
  endtask
  // test port reset pulse with the test clock held still
  task automatic treset;
    trst_n = 1'b0;
    #40 trst_n = 1'b1;
  endtask
  // select an instruction and idle; tdi toggles when unused
  task automatic pick(input logic [5:0] s);
    sel = s;
    repeat (8) cyc(0, 0, 0, ~tdi);
  endtask
  // capture, shift v with cell 60 first, update
  task automatic scan(input logic [60:1] v, output logic [60:1] cap);
    cyc(1, 0, 0, ~tdi);
    for (int k = 60; k >= 1; k--) begin
      cap[k] = chain_tdo;
      cyc(0, 1, 0, v[k]);
    end
    cyc(0, 0, 1, ~tdi);
    repeat (8) cyc(0, 0, 0, ~tdi);
  endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the boundary-scan cell chain
`timescale 1ns/100ps
module testbench;
  localparam logic [60:1] IN = 60'h69e_2049_54aa_a20d;
  localparam logic [60:1] EN = 60'h100_0000_0020;
  localparam logic [60:1] G6 = 60'h2_a955_4410;
  localparam logic [60:1] G41 = 60'h80_0000_0000;
  localparam logic [60:1] OUT = ~(IN | EN);
  // guard positions: zeros before extest/clamps, ones and zeros before intest
  localparam logic [60:1] EXZ = 60'h69e_2048_0000_0005;
  localparam logic [60:1] IN1 = 60'h940_0120_0000_0020;
  localparam logic [60:1] IN0 = OUT & ~G6 & ~IN1;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [60:1] pad_in = '0, core_out = '0, core_oe_n = '0, v, cap, to_core, pad_out, pad_oe;
  logic [31:0] seed = 32'hdc16_1cbc;
  logic tck, trst_n, tdi, capture_dr, shift_dr, update_dr, chain_tdo;
  logic [5:0] sel;
  logic [5:0] s;
  logic [60:1] vx, vi, w, ev;
  int fail_count = 0;
  int checks = 0;
  bsc_chain dut (.clk, .rst_n, .tck, .trst_n, .tdi, .capture_dr, .shift_dr, .update_dr,
    .sel_sample(sel[0]), .sel_extest(sel[1]), .sel_intest(sel[2]), .sel_clamp(sel[3]),
    .sel_clamp_with_outputs_disabled(sel[4]), .sel_highz(sel[5]), .chain_tdo, .pad_in,
    .core_out, .core_oe_n, .to_core, .pad_out, .pad_oe);
  bsc_tester tester (.tck, .trst_n, .tdi, .capture_dr, .shift_dr, .update_dr, .sel, .chain_tdo);
  // xorshift source, 60 bits per call
  function automatic logic [60:1] rnd();
    logic [31:0] a;
    a = seed ^ (seed << 13);
    a = a ^ (a >> 17);
    seed = a ^ (a << 5);
    return {a[27:0], seed};
  endfunction
  // pad drive mask for the two enable cell values
  function automatic logic [60:1] oe_of(input logic e6, e41);
    return OUT & ~(e6 ? G6 : '0) & ~(e41 ? G41 : '0);
  endfunction
  // compare and count
  task automatic chk(input logic [60:1] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    repeat (12) @(posedge clk);
  endtask
  task automatic results;
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////
  initial begin
    forever #25 clk = ~clk;
  end
  // hang guard
  initial begin
    #300_000;
    fail_count++;
    results;
  end
  // normal, preload, extest, preload, intest, preload, refused scan, clamp_with_outputs_disabled, highz per round
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      pad_in <= rnd();
      core_out <= rnd();
      core_oe_n <= (r < 2) ? {60{r[0]}} : rnd();
      v = (r == 0) ? '1 : rnd();
      w = rnd();
      // clamp, clamp_with_outputs_disabled, highz or no instruction for the refused scan
      s = (r == 0) ? 6'h08 : 6'(6'h08 << w[2:1]);
      vx = v & ~EXZ;
      vi = v & ~IN0 | IN1;
      // mid-run system reset
      if (r == 1) begin
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(pad_oe, '0);
        chk(pad_out | to_core, '0);
        rst_n <= 1'b1;
      end
      // mid-run test port reset clears the shift cells
      if (r == 2) begin
        tester.treset();
        chk(chain_tdo, '0);
      end
      tester.pick(6'h00);
      settle;
      chk(pad_out, core_out & OUT);
      chk(to_core, pad_in & IN);
      chk(pad_oe, oe_of(core_oe_n[6], core_oe_n[41]));
      tester.pick(6'h01);
      tester.scan(vx, cap);
      chk(cap, pad_in & IN | core_out & OUT | core_oe_n & EN);
      tester.pick(6'h02);
      settle;
      chk(pad_out, vx & OUT);
      chk(to_core, vx & IN);
      chk(pad_oe, oe_of(vx[6], vx[41]));
      tester.pick(6'h01);
      tester.scan(vi, cap);
      chk(cap, pad_in & IN | core_out & OUT | core_oe_n & EN);
      tester.pick(6'h04);
      settle;
      chk(pad_out, vi & OUT);
      chk(to_core, vi & IN);
      chk(pad_oe, oe_of(vi[6], vi[41]));
      tester.scan(vi, cap);
      chk(cap, ~vi & IN | core_out & OUT | core_oe_n & EN);
      tester.pick(6'h01);
      tester.scan(vx, cap);
      chk(cap, pad_in & IN | core_out & OUT | core_oe_n & EN);
      // chain not selected: nothing captured, shifted or updated
      tester.pick(s);
      tester.scan(~vx, cap);
      settle;
      ev = s[3] ? vx : core_oe_n;
      chk(cap, {60{vx[60]}});
      chk(pad_out, (s[3] | s[4]) ? vx & OUT : core_out & OUT);
      chk(to_core, pad_in & IN);
      chk(pad_oe, (s[4] | s[5]) ? '0 : oe_of(ev[6], ev[41]));
      tester.pick(6'h10);
      settle;
      chk(pad_oe, '0);
      chk(pad_out, vx & OUT);
      tester.pick(6'h20);
      settle;
      chk(pad_oe, '0);
      chk(pad_out, core_out & OUT);
    end
    results;
  end
endmodule
